//--- alarm_pin_defs.svh
// offsets, reset values, writable masks and bit positions of the alarm pin block
// assumes byte-wide registers on a simple synchronous register port
`ifndef ALARM_PIN_DEFS_SVH
`define ALARM_PIN_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define OFS_COARSE_SKEW 8'h10
`define OFS_PIN_EN 8'h14
`define OFS_SRC_SEL 8'h15
`define OFS_POL 8'h16
`define OFS_LOS_MSK 8'h17

// ---------------------------------------------------------------
// reset values and writable bits
// ---------------------------------------------------------------
`define RST_COARSE_SKEW 8'h00
`define RST_PIN_EN 8'h3E
`define RST_SRC_SEL 8'hFF
`define RST_POL 8'hDF
`define RST_LOS_MSK 8'h07
`define WMSK_COARSE_SKEW 8'hFF
`define WMSK_PIN_EN 8'h0F
`define WMSK_SRC_SEL 8'h83
`define WMSK_POL 8'h0F
`define WMSK_LOS_MSK 8'h07
`define RD_UNMAPPED 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_C2_EN 3
`define BIT_C1_EN 2
`define BIT_LOL_EN 1
`define BIT_IRQ_ROUTE 0
`define BIT_SKEW_SRC 7
`define BIT_FORCE_ONE 6
`define BIT_ACT_EN 1
`define BIT_SEL_SRC 0
`define BIT_ACT_POL 3
`define BIT_FLT_POL 2
`define BIT_LOCK_LOSS_POLARITY 1
`define BIT_IRQ_POL 0
`define BIT_IN2_MSK 2
`define BIT_IN1_MSK 1
`define BIT_XTL_MSK 0

// ---------------------------------------------------------------
// skew limits and clock select codes
// ---------------------------------------------------------------
`define SKEW_MAX 8'sh7F
`define SKEW_MIN 8'sh80
`define SKEW_ONE 8'sh01
`define SEL_INPUT1 2'h0
`define SEL_INPUT2 2'h1

`endif

//--- alarm_pin_pkg.sv
// types shared by the alarm pin routing block
// assumes alarm_pin_defs.svh supplies all numeric constants
package alarm_pin_pkg;
    typedef logic [7:0] cfg_byte_t;
    typedef logic signed [7:0] skew_t;
    typedef logic [1:0] clk_sel_t;
endpackage

//--- status_pad_driver.sv
// one tristatable status pad: polarity and enable applied, then registered
// assumes the pad cell merges out and oe_n; oe_n low means driven
`timescale 1ns/10ps
`include "alarm_pin_defs.svh"

module status_pad_driver
    import alarm_pin_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic status_i,
    input wire logic polarity_i,
    input wire logic enable_i,
    output logic pad_o,
    output logic pad_oe_n_o
);
    logic pad_next;
    logic oe_n_next;

    always_comb begin
        pad_next = polarity_i ? status_i : ~status_i;
        oe_n_next = ~enable_i;
    end

    // released pads start tristated so nothing fights the board at power-up
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pad_o <= 1'b0;
            pad_oe_n_o <= 1'b1;
        end else begin
            pad_o <= pad_next;
            pad_oe_n_o <= oe_n_next;
        end
    end
endmodule

//--- coarse_skew_ctrl.sv
// coarse output phase: follows the skew register or steps on pin edges
// assumes step pads are synchronous to clk_sys_i
`timescale 1ns/10ps
`include "alarm_pin_defs.svh"

module coarse_skew_ctrl
    import alarm_pin_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic skew_source_select_i,
    input wire logic [7:0] coarse_skew_reg_i,
    input wire logic phase_step_up_pad_i,
    input wire logic phase_step_down_pad_i,
    output logic [7:0] phase_offset_o
);
    skew_t offset_reg;
    skew_t offset_next;
    logic up_prev_reg;
    logic up_prev_next;
    logic dn_prev_reg;
    logic dn_prev_next;
    logic up_edge;
    logic dn_edge;

    always_comb begin
        up_prev_next = phase_step_up_pad_i;
        dn_prev_next = phase_step_down_pad_i;
        up_edge = phase_step_up_pad_i & ~up_prev_reg;
        dn_edge = phase_step_down_pad_i & ~dn_prev_reg;
        offset_next = offset_reg;
        if (!skew_source_select_i) begin
            offset_next = skew_t'(coarse_skew_reg_i);
        end else if (up_edge && !dn_edge && offset_reg != `SKEW_MAX) begin
            offset_next = offset_reg + `SKEW_ONE;
        end else if (dn_edge && !up_edge && offset_reg != `SKEW_MIN) begin
            offset_next = offset_reg - `SKEW_ONE;
        end
    end

    // saturating rather than wrapping: a wrap would jump the phase a full period
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            offset_reg <= skew_t'(`RST_COARSE_SKEW);
            up_prev_reg <= 1'b0;
            dn_prev_reg <= 1'b0;
        end else begin
            offset_reg <= offset_next;
            up_prev_reg <= up_prev_next;
            dn_prev_reg <= dn_prev_next;
        end
    end

    assign phase_offset_o = offset_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_skew_follows_reg: assert property (
        !skew_source_select_i |=> phase_offset_o == $past(coarse_skew_reg_i))
        else $error("coarse skew does not follow register");
    a_skew_pins_ignored: assert property (
        $past(!skew_source_select_i) && !skew_source_select_i && $stable(coarse_skew_reg_i)
        |=> $stable(phase_offset_o))
        else $error("skew moved under register control");
    a_skew_step_up: assert property (
        skew_source_select_i && up_edge && !dn_edge && offset_reg != `SKEW_MAX
        |=> offset_reg == $past(offset_reg) + `SKEW_ONE)
        else $error("step up did not add one");
    c_skew_saturate: cover property (
        skew_source_select_i && up_edge && offset_reg == `SKEW_MAX);
endmodule

//--- alarm_pin_ctrl.sv
// alarm pin routing, polarity, select source and loss masking
// assumes register port and all status inputs are synchronous to clk_sys_i
// latched loss flags live elsewhere; this block only reads them
`timescale 1ns/10ps
`include "alarm_pin_defs.svh"

// What this block does
// - clock-2 fault pad tristated when its enable is 0, else shows fault status.
// - shared pad tristated when clock-1 enable is 0, else input-1 loss or irq.
// - lock-loss pad tristated when its enable is 0, else shows lock-loss status.
// - routing bit 1 puts irq on shared pad; 0 puts input-1 loss there.
// - pin enable register resets to 0x3E; upper four bits read-only.
// - skew source 0 uses skew register; 1 lets step pads move phase.
// - active pad tristated when its enable is 0 or it is acting as the select input, else shows clock-1 active.
// - in manual mode, select source bit picks select pad or register field.
// - select source register resets to 0xFF; bit 6 forced 1; bits 5:2 read-only.
// - active polarity bit sets active level of the active pad.
// - fault polarity bit sets level of clock-2 fault pad and of input-1 loss on shared pad.
// - lock-loss polarity bit sets level of lock-loss pad.
// - irq polarity bit sets level of irq on shared pad.
// - polarity register resets to 0xDF; upper four bits read-only.
// - unmasked input-2 loss flag raises the irq.
// - unmasked input-1 loss flag raises the irq.
// - unmasked crystal loss flag raises the irq.
// - mask writes never alter the latched loss flags.
// - skew register is two's complement phase, -128 to +127 oscillator periods.
module alarm_pin_ctrl
    import alarm_pin_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_en_i,
    input wire logic [7:0] reg_wr_data_i,
    output logic [7:0] reg_rd_data_o,
    input wire logic clock2_fault_status_i,
    input wire logic input1_signal_loss_i,
    input wire logic lock_loss_status_i,
    input wire logic clock1_active_status_i,
    input wire logic input1_loss_flag_i,
    input wire logic input2_loss_flag_i,
    input wire logic crystal_loss_flag_i,
    input wire logic auto_selection_mode_i,
    input wire logic [1:0] select_register_field_i,
    input wire logic phase_step_up_pad_i,
    input wire logic phase_step_down_pad_i,
    output logic clock2_fault_pad_o,
    output logic clock2_fault_pad_oe_n_o,
    output logic shared_fault_irq_pad_o,
    output logic shared_fault_irq_pad_oe_n_o,
    output logic lock_loss_pad_o,
    output logic lock_loss_pad_oe_n_o,
    input wire logic select_active_pad_i,
    output logic select_active_pad_o,
    output logic select_active_pad_oe_n_o,
    output logic irq_status_o,
    output logic [1:0] clock_select_o,
    output logic [7:0] phase_offset_o
);
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic cfg_byte_t merge_write(input cfg_byte_t old_val,
                                              input cfg_byte_t wr_val,
                                              input cfg_byte_t wr_mask);
        merge_write = (old_val & ~wr_mask) | (wr_val & wr_mask);
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    cfg_byte_t coarse_skew_reg;
    cfg_byte_t coarse_skew_next;
    cfg_byte_t pin_en_reg;
    cfg_byte_t pin_en_next;
    cfg_byte_t src_sel_reg;
    cfg_byte_t src_sel_next;
    cfg_byte_t pol_reg;
    cfg_byte_t pol_next;
    cfg_byte_t los_msk_reg;
    cfg_byte_t los_msk_next;
    cfg_byte_t rd_data_next;

    always_comb begin
        coarse_skew_next = coarse_skew_reg;
        pin_en_next = pin_en_reg;
        src_sel_next = src_sel_reg;
        pol_next = pol_reg;
        los_msk_next = los_msk_reg;
        if (reg_wr_en_i) begin
            if (hit(reg_addr_i, `OFS_COARSE_SKEW)) begin
                coarse_skew_next = merge_write(coarse_skew_reg, reg_wr_data_i,
                                               `WMSK_COARSE_SKEW);
            end
            if (hit(reg_addr_i, `OFS_PIN_EN)) begin
                pin_en_next = merge_write(pin_en_reg, reg_wr_data_i, `WMSK_PIN_EN);
            end
            if (hit(reg_addr_i, `OFS_SRC_SEL)) begin
                // bit 6 and bits 5:2 sit outside the mask so keep their reset ones
                src_sel_next = merge_write(src_sel_reg, reg_wr_data_i, `WMSK_SRC_SEL);
            end
            if (hit(reg_addr_i, `OFS_POL)) begin
                pol_next = merge_write(pol_reg, reg_wr_data_i, `WMSK_POL);
            end
            if (hit(reg_addr_i, `OFS_LOS_MSK)) begin
                // masks gate only the irq term; flag storage is not reachable here
                los_msk_next = merge_write(los_msk_reg, reg_wr_data_i, `WMSK_LOS_MSK);
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            coarse_skew_reg <= `RST_COARSE_SKEW;
            pin_en_reg <= `RST_PIN_EN;
            src_sel_reg <= `RST_SRC_SEL;
            pol_reg <= `RST_POL;
            los_msk_reg <= `RST_LOS_MSK;
        end else begin
            coarse_skew_reg <= coarse_skew_next;
            pin_en_reg <= pin_en_next;
            src_sel_reg <= src_sel_next;
            pol_reg <= pol_next;
            los_msk_reg <= los_msk_next;
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    // one cycle of latency keeps the read data off a long mux path
    always_comb begin
        unique case (reg_addr_i)
            `OFS_COARSE_SKEW: rd_data_next = coarse_skew_reg;
            `OFS_PIN_EN: rd_data_next = pin_en_reg;
            `OFS_SRC_SEL: rd_data_next = src_sel_reg;
            `OFS_POL: rd_data_next = pol_reg;
            `OFS_LOS_MSK: rd_data_next = los_msk_reg;
            default: rd_data_next = `RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rd_data_o <= `RD_UNMAPPED;
        end else begin
            reg_rd_data_o <= rd_data_next;
        end
    end

    // ---------------------------------------------------------------
    // interrupt and pad routing
    // ---------------------------------------------------------------
    logic irq_raw;
    logic irq_next;
    logic shared_status;
    logic shared_pol;
    logic pin_select;
    logic act_drive_en;
    clk_sel_t clk_sel_next;

    always_comb begin
        irq_raw = (input2_loss_flag_i & ~los_msk_reg[`BIT_IN2_MSK])
                | (input1_loss_flag_i & ~los_msk_reg[`BIT_IN1_MSK])
                | (crystal_loss_flag_i & ~los_msk_reg[`BIT_XTL_MSK]);
        irq_next = irq_raw;
        if (pin_en_reg[`BIT_IRQ_ROUTE]) begin
            shared_status = irq_raw;
            shared_pol = pol_reg[`BIT_IRQ_POL];
        end else begin
            shared_status = input1_signal_loss_i;
            shared_pol = pol_reg[`BIT_FLT_POL];
        end
        pin_select = ~auto_selection_mode_i & src_sel_reg[`BIT_SEL_SRC];
        // never drive the pad while it is acting as the select input
        act_drive_en = src_sel_reg[`BIT_ACT_EN] & ~pin_select;
        if (pin_select) begin
            clk_sel_next = select_active_pad_i ? `SEL_INPUT2 : `SEL_INPUT1;
        end else begin
            clk_sel_next = select_register_field_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_status_o <= 1'b0;
            clock_select_o <= `SEL_INPUT1;
        end else begin
            irq_status_o <= irq_next;
            clock_select_o <= clk_sel_next;
        end
    end

    status_pad_driver u_clock2_fault_pad (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .status_i(clock2_fault_status_i),
        .polarity_i(pol_reg[`BIT_FLT_POL]),
        .enable_i(pin_en_reg[`BIT_C2_EN]),
        .pad_o(clock2_fault_pad_o),
        .pad_oe_n_o(clock2_fault_pad_oe_n_o)
    );

    status_pad_driver u_shared_fault_irq_pad (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .status_i(shared_status),
        .polarity_i(shared_pol),
        .enable_i(pin_en_reg[`BIT_C1_EN]),
        .pad_o(shared_fault_irq_pad_o),
        .pad_oe_n_o(shared_fault_irq_pad_oe_n_o)
    );

    status_pad_driver u_lock_loss_pad (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .status_i(lock_loss_status_i),
        .polarity_i(pol_reg[`BIT_LOCK_LOSS_POLARITY]),
        .enable_i(pin_en_reg[`BIT_LOL_EN]),
        .pad_o(lock_loss_pad_o),
        .pad_oe_n_o(lock_loss_pad_oe_n_o)
    );

    status_pad_driver u_select_active_pad (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .status_i(clock1_active_status_i),
        .polarity_i(pol_reg[`BIT_ACT_POL]),
        .enable_i(act_drive_en),
        .pad_o(select_active_pad_o),
        .pad_oe_n_o(select_active_pad_oe_n_o)
    );

    coarse_skew_ctrl u_coarse_skew (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .skew_source_select_i(src_sel_reg[`BIT_SKEW_SRC]),
        .coarse_skew_reg_i(coarse_skew_reg),
        .phase_step_up_pad_i(phase_step_up_pad_i),
        .phase_step_down_pad_i(phase_step_down_pad_i),
        .phase_offset_o(phase_offset_o)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    a_c2_pad_float: assert property (
        !pin_en_reg[`BIT_C2_EN] |=> clock2_fault_pad_oe_n_o)
        else $error("clock-2 fault pad driven while disabled");
    a_c2_pad_level: assert property (
        pin_en_reg[`BIT_C2_EN] |=> !clock2_fault_pad_oe_n_o
            && clock2_fault_pad_o == ($past(clock2_fault_status_i) ~^ $past(pol_reg[2])))
        else $error("clock-2 fault pad level wrong");
    a_shared_pad_float: assert property (
        !pin_en_reg[`BIT_C1_EN] |=> shared_fault_irq_pad_oe_n_o)
        else $error("shared pad driven while disabled");
    a_shared_los_route: assert property (
        pin_en_reg[`BIT_C1_EN] && !pin_en_reg[`BIT_IRQ_ROUTE]
        |=> shared_fault_irq_pad_o == ($past(input1_signal_loss_i) ~^ $past(pol_reg[2])))
        else $error("shared pad not showing input-1 loss");
    a_shared_irq_route: assert property (
        pin_en_reg[`BIT_C1_EN] && pin_en_reg[`BIT_IRQ_ROUTE]
        |=> shared_fault_irq_pad_o == (irq_status_o ~^ $past(pol_reg[0])))
        else $error("shared pad not showing irq");
    a_lol_pad_level: assert property (
        pin_en_reg[`BIT_LOL_EN] |=> !lock_loss_pad_oe_n_o
            && lock_loss_pad_o == ($past(lock_loss_status_i) ~^ $past(pol_reg[1])))
        else $error("lock-loss pad level wrong");
    a_lol_pad_float: assert property (
        !pin_en_reg[`BIT_LOL_EN] |=> lock_loss_pad_oe_n_o)
        else $error("lock-loss pad driven while disabled");
    a_act_pad_level: assert property (
        act_drive_en |=> !select_active_pad_oe_n_o
            && select_active_pad_o == ($past(clock1_active_status_i) ~^ $past(pol_reg[3])))
        else $error("active pad level wrong");
    a_act_pad_float: assert property (
        !src_sel_reg[`BIT_ACT_EN] |=> select_active_pad_oe_n_o)
        else $error("active pad driven while disabled");
    a_select_source: assert property (
        !auto_selection_mode_i && !src_sel_reg[`BIT_SEL_SRC]
        |=> clock_select_o == $past(select_register_field_i))
        else $error("select pad not ignored");
    a_irq_masking: assert property (
        1'b1 |=> irq_status_o ==
            (($past(input2_loss_flag_i) && !$past(los_msk_reg[`BIT_IN2_MSK]))
            || ($past(input1_loss_flag_i) && !$past(los_msk_reg[`BIT_IN1_MSK]))
            || ($past(crystal_loss_flag_i) && !$past(los_msk_reg[`BIT_XTL_MSK]))))
        else $error("irq not the OR of unmasked flags");
    a_reserved_bits: assert property (
        src_sel_reg[`BIT_FORCE_ONE] && src_sel_reg[5:2] == 4'hF
        && pin_en_reg[7:4] == 4'h3 && pol_reg[7:4] == 4'hD)
        else $error("reserved bits changed");
    a_read_after_write: assert property (
        reg_wr_en_i && reg_addr_i == `OFS_PIN_EN
        ##1 reg_addr_i == `OFS_PIN_EN && !reg_wr_en_i
        |=> reg_rd_data_o == {4'h3, $past(reg_wr_data_i[3:0], 2)})
        else $error("pin enable readback wrong");

    c_irq_on_pad: cover property (
        pin_en_reg[`BIT_C1_EN] && pin_en_reg[`BIT_IRQ_ROUTE] && irq_raw);
    c_pin_select: cover property (pin_select && select_active_pad_i);
    c_mask_write: cover property (
        reg_wr_en_i && reg_addr_i == `OFS_LOS_MSK && input1_loss_flag_i);
endmodule

//--- board_model.sv
// board logic beside the alarm pins: phase step pads and the shared select line
// assumes bench requests change just after a rising clk_sys_i edge
`timescale 1ns/10ps

module board_model (
    input wire logic clk_sys_i,
    input wire logic step_up_req_i,
    input wire logic step_down_req_i,
    input wire logic select_req_i,
    input wire logic active_pad_i,
    input wire logic active_pad_oe_n_i,
    output logic phase_step_up_pad_o,
    output logic phase_step_down_pad_o,
    output logic select_wire_o
);
    logic up_reg;
    logic down_reg;

    // step pads move on the edge, so the device sees one clean level per cycle
    always_ff @(posedge clk_sys_i) begin
        up_reg <= step_up_req_i;
        down_reg <= step_down_req_i;
    end
    assign phase_step_up_pad_o = up_reg;
    assign phase_step_down_pad_o = down_reg;

    // board drives the select line only while the device floats it, never fights it
    assign select_wire_o = active_pad_oe_n_i ? select_req_i : active_pad_i;
endmodule

//--- tb.sv
// self-checking bench for the alarm pin block and its board model
// assumes 10 MHz clock, inputs driven 10 ns after each rising edge
`timescale 1ns/10ps
`include "alarm_pin_defs.svh"

module tb;
    import alarm_pin_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_en = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic [7:0] rd_data;
    logic st_c2 = 1'b0, st_in1 = 1'b0, st_lol = 1'b0, st_act = 1'b0;
    logic f1 = 1'b0, f2 = 1'b0, fx = 1'b0, auto_mode = 1'b0;
    logic [1:0] sel_field = 2'h0;
    logic up_req = 1'b0, dn_req = 1'b0, sel_req = 1'b0;
    logic up_pad, dn_pad, sel_wire, c2_pad, c2_oe_n, sh_pad, sh_oe_n;
    logic lol_pad, lol_oe_n, act_pad, act_oe_n, irq;
    logic [1:0] csel;
    logic [7:0] phase;
    logic [3:0] en, pol;
    logic st;
    int errors = 0;
    int compares = 0;
    int cycles = 0;

    alarm_pin_ctrl u_alarm_pin_ctrl (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_en_i(wr_en), .reg_wr_data_i(wr_data),
        .reg_rd_data_o(rd_data), .clock2_fault_status_i(st_c2),
        .input1_signal_loss_i(st_in1), .lock_loss_status_i(st_lol),
        .clock1_active_status_i(st_act), .input1_loss_flag_i(f1),
        .input2_loss_flag_i(f2), .crystal_loss_flag_i(fx),
        .auto_selection_mode_i(auto_mode), .select_register_field_i(sel_field),
        .phase_step_up_pad_i(up_pad), .phase_step_down_pad_i(dn_pad),
        .clock2_fault_pad_o(c2_pad), .clock2_fault_pad_oe_n_o(c2_oe_n),
        .shared_fault_irq_pad_o(sh_pad), .shared_fault_irq_pad_oe_n_o(sh_oe_n),
        .lock_loss_pad_o(lol_pad), .lock_loss_pad_oe_n_o(lol_oe_n),
        .select_active_pad_i(sel_wire), .select_active_pad_o(act_pad),
        .select_active_pad_oe_n_o(act_oe_n), .irq_status_o(irq),
        .clock_select_o(csel), .phase_offset_o(phase));

    board_model u_board_model (.clk_sys_i(clk_sys_i), .step_up_req_i(up_req),
        .step_down_req_i(dn_req), .select_req_i(sel_req), .active_pad_i(act_pad),
        .active_pad_oe_n_i(act_oe_n), .phase_step_up_pad_o(up_pad),
        .phase_step_down_pad_o(dn_pad), .select_wire_o(sel_wire));

    // ---------------------------------------------------------------
    // clock, timeout and tasks
    // ---------------------------------------------------------------
    always #50 clk_sys_i = ~clk_sys_i;

    // whole run needs under 2000 cycles; the ceiling leaves wide margin
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (errors == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        tick(1);
        wr_en = 1'b0;
        // idle edge so a following write never re-raises the strobe in one step
        tick(1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        tick(1);
        chk(rd_data, exp);
    endtask

    // low cycle between pulses so every request is a fresh rising edge
    task automatic step(input logic up, input int n);
        repeat (n) begin
            up_req = up;
            dn_req = ~up;
            tick(1);
            up_req = 1'b0;
            dn_req = 1'b0;
            tick(1);
        end
        tick(3);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        tick(5);
        sys_rst_i = 1'b0;
        rd(`OFS_PIN_EN, 8'h3E);
        rd(`OFS_SRC_SEL, 8'hFF);
        rd(`OFS_POL, 8'hDF);
        rd(`OFS_LOS_MSK, 8'h07);
        rd(8'h20, 8'h00);
        wr(8'h20, 8'h55);
        wr(`OFS_PIN_EN, 8'hFF);
        rd(`OFS_PIN_EN, 8'h3F);
        wr(`OFS_SRC_SEL, 8'h00);
        rd(`OFS_SRC_SEL, 8'h7C);
        wr(`OFS_POL, 8'hF0);
        rd(`OFS_POL, 8'hD0);
        wr(`OFS_LOS_MSK, 8'h00);
        for (int i = 0; i < 64; i++) begin
            en = i[3:0];
            pol = {i[4], ~i[4], i[4], i[4]};
            st = i[5];
            st_c2 = st;
            st_in1 = ~st;
            st_lol = st;
            f2 = st;
            wr(`OFS_PIN_EN, {4'h0, en});
            wr(`OFS_POL, {4'h0, pol});
            tick(2);
            chk({7'h00, c2_oe_n}, {7'h00, ~en[3]});
            if (en[3]) chk({7'h00, c2_pad}, {7'h00, st ~^ pol[2]});
            chk({7'h00, sh_oe_n}, {7'h00, ~en[2]});
            if (en[2]) chk({7'h00, sh_pad},
                {7'h00, en[0] ? st ~^ pol[0] : ~st ~^ pol[2]});
            chk({7'h00, lol_oe_n}, {7'h00, ~en[1]});
            if (en[1]) chk({7'h00, lol_pad}, {7'h00, st ~^ pol[1]});
        end
        for (int i = 0; i < 64; i++) begin
            {f2, f1, fx} = i[2:0];
            wr(`OFS_LOS_MSK, {5'h00, i[5:3]});
            tick(1);
            chk({7'h00, irq}, {7'h00, |(i[2:0] & ~i[5:3])});
            wr(`OFS_LOS_MSK, 8'h00);
            tick(1);
            chk({7'h00, irq}, {7'h00, |i[2:0]});
        end
        // active pad and clock selection in manual mode, then in auto mode
        st_act = 1'b1;
        sel_field = 2'h1;
        wr(`OFS_SRC_SEL, 8'h02);
        wr(`OFS_POL, 8'h00);
        tick(2);
        chk({7'h00, act_oe_n}, 8'h00);
        chk({7'h00, act_pad}, 8'h00);
        chk({6'h00, csel}, 8'h01);
        wr(`OFS_POL, 8'h08);
        tick(2);
        chk({7'h00, act_pad}, 8'h01);
        wr(`OFS_SRC_SEL, 8'h03);
        tick(2);
        chk({7'h00, act_oe_n}, 8'h01);
        chk({6'h00, csel}, 8'h00);
        sel_req = 1'b1;
        sel_field = 2'h0;
        tick(2);
        chk({6'h00, csel}, 8'h01);
        auto_mode = 1'b1;
        tick(2);
        chk({6'h00, csel}, 8'h00);
        auto_mode = 1'b0;
        // coarse skew from register, then from step pads with saturation
        wr(`OFS_SRC_SEL, 8'h00);
        wr(`OFS_COARSE_SKEW, 8'h7E);
        step(1'b1, 3);
        chk(phase, 8'h7E);
        wr(`OFS_SRC_SEL, 8'h80);
        step(1'b1, 3);
        chk(phase, 8'h7F);
        step(1'b0, 1);
        chk(phase, 8'h7E);
        wr(`OFS_SRC_SEL, 8'h00);
        wr(`OFS_COARSE_SKEW, 8'h81);
        tick(2);
        chk(phase, 8'h81);
        wr(`OFS_SRC_SEL, 8'h80);
        step(1'b0, 3);
        chk(phase, 8'h80);
        end_sim();
    end
endmodule
